// ===== fcs_bus_engine.sv
`timescale 1ns/10ps
module fcs_bus_engine (
  input  wire logic  clk_sys,
  input  wire logic  resetn,
  fcs_cyc_if.eng     cyc,
  output logic [16:0] fl_addr,
  output logic [7:0]  fl_dq_out,
  output logic        fl_dq_oe,
  input  wire logic [7:0] fl_dq_in,
  output logic        fl_ce_n,
  output logic        fl_we_n,
  output logic        fl_oe_n
);
  typedef enum logic [2:0] {
    E_IDLE   = 3'b000,
    E_SETUP  = 3'b001,
    E_STROBE = 3'b010,
    E_HOLD   = 3'b011,
    E_READ   = 3'b100,
    E_GAP    = 3'b101
  } fcs_eng_st_t;

  fcs_eng_st_t st;
  logic [3:0]  cnt;
  logic [7:0]  dq_s1;
  logic [7:0]  dq_s2;

  // =====================================================
  // data input synchroniser
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      dq_s1 <= 8'h00;
      dq_s2 <= 8'h00;
    end else begin
      dq_s1 <= fl_dq_in;
      dq_s2 <= dq_s1;
    end
  end

  // =====================================================
  // one bus cycle per request; chip select frames every cycle so each
  // read is a fresh pulse and the toggle bits advance
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      st        <= E_IDLE;
      cnt       <= 4'h0;
      cyc.done  <= 1'b0;
      cyc.rdata <= 8'h00;
      fl_addr   <= 17'h00000;
      fl_dq_out <= 8'h00;
      fl_dq_oe  <= 1'b0;
      fl_ce_n   <= 1'b1;
      fl_we_n   <= 1'b1;
      fl_oe_n   <= 1'b1;
    end else begin
      case (st)
        E_IDLE: begin
          cyc.done <= 1'b0;
          if (cyc.req) begin
            fl_addr <= cyc.addr;
            fl_ce_n <= 1'b0;
            if (cyc.wr) begin
              fl_dq_out <= cyc.wdata;
              fl_dq_oe  <= 1'b1;
              st        <= E_SETUP;
            end else begin
              fl_oe_n <= 1'b0;
              cnt     <= fcs_pkg::READ_CYC;
              st      <= E_READ;
            end
          end
        end
        E_SETUP: begin
          // address stood a full cycle before the later strobe falls
          fl_we_n <= 1'b0;
          cnt     <= fcs_pkg::WP_CYC - 4'h1;
          st      <= E_STROBE;
        end
        E_STROBE: begin
          if (cnt == 4'h0) begin
            fl_we_n <= 1'b1;
            st      <= E_HOLD;
          end else begin
            cnt <= cnt - 4'h1;
          end
        end
        E_HOLD: begin
          // data still driven while the earlier strobe rises
          fl_ce_n <= 1'b1;
          st      <= E_GAP;
        end
        E_READ: begin
          if (cnt == 4'h0) begin
            cyc.rdata <= dq_s2;
            fl_ce_n   <= 1'b1;
            fl_oe_n   <= 1'b1;
            st        <= E_GAP;
          end else begin
            cnt <= cnt - 4'h1;
          end
        end
        E_GAP: begin
          fl_dq_oe <= 1'b0;
          cyc.done <= 1'b1;
          st       <= E_IDLE;
        end
        default: st <= E_IDLE;
      endcase
    end
  end
endmodule

// ===== fcs_ctrl.sv
`timescale 1ns/10ps
module fcs_ctrl (
  input  wire logic        clk_sys,
  input  wire logic        resetn,
  input  wire logic        cmd_valid,
  input  wire logic [3:0]  cmd_code,
  input  wire logic [16:0] cmd_addr,
  input  wire logic [7:0]  cmd_data,
  output logic             cmd_ready,
  output logic             rsp_valid,
  output logic [7:0]       rsp_data,
  output logic             rsp_fail,
  output logic [16:0]      fl_addr,
  output logic [7:0]       fl_dq_out,
  output logic             fl_dq_oe,
  input  wire logic [7:0]  fl_dq_in,
  output logic             fl_ce_n,
  output logic             fl_we_n,
  output logic             fl_oe_n
);
  typedef enum logic [3:0] {
    S_IDLE    = 4'b0000,
    S_SEQ     = 4'b0001,
    S_SEQ_W   = 4'b0010,
    S_POLL    = 4'b0011,
    S_POLL_W  = 4'b0100,
    S_FIN     = 4'b0101,
    S_FIN_W   = 4'b0110,
    S_ABORT   = 4'b0111,
    S_ABORT_W = 4'b1000,
    S_DONE    = 4'b1001
  } fcs_st_t;

  fcs_cyc_if cyc ();

  fcs_bus_engine u_eng (
    .clk_sys   (clk_sys),
    .resetn    (resetn),
    .cyc       (cyc.eng),
    .fl_addr   (fl_addr),
    .fl_dq_out (fl_dq_out),
    .fl_dq_oe  (fl_dq_oe),
    .fl_dq_in  (fl_dq_in),
    .fl_ce_n   (fl_ce_n),
    .fl_we_n   (fl_we_n),
    .fl_oe_n   (fl_oe_n)
  );

  // =====================================================
  // command sequence tables
  function automatic logic [2:0] seq_len(input logic [3:0] c);
    case (c)
      fcs_pkg::CMD_PROGRAM:   seq_len = 3'd4;
      fcs_pkg::CMD_BYP_ENTER: seq_len = 3'd3;
      fcs_pkg::CMD_BYP_PROG:  seq_len = 3'd2;
      fcs_pkg::CMD_BYP_EXIT:  seq_len = 3'd2;
      fcs_pkg::CMD_CHIP_ERS:  seq_len = 3'd6;
      fcs_pkg::CMD_SECT_ERS:  seq_len = 3'd6;
      fcs_pkg::CMD_AUTOSEL:   seq_len = 3'd3;
      fcs_pkg::CMD_READ:      seq_len = 3'd0;
      fcs_pkg::CMD_POLL:      seq_len = 3'd0;
      default:                seq_len = 3'd1;
    endcase
  endfunction

  // returns {address, data}; unlock cycles drive bits 16..11 low
  function automatic logic [24:0] seq_word(input logic [3:0]  c,
                                           input logic [2:0]  i,
                                           input logic [16:0] a,
                                           input logic [7:0]  d);
    logic [7:0] third;
    third = fcs_pkg::D_AUTOSEL;
    seq_word = {fcs_pkg::A_ANY, fcs_pkg::D_RESET};
    case (c)
      fcs_pkg::CMD_PROGRAM:  third = fcs_pkg::D_PROGRAM;
      fcs_pkg::CMD_BYP_ENTER: third = fcs_pkg::D_BYPASS;
      fcs_pkg::CMD_CHIP_ERS, fcs_pkg::CMD_SECT_ERS: third = fcs_pkg::D_ERASE;
      default: third = fcs_pkg::D_AUTOSEL;
    endcase
    case (c)
      fcs_pkg::CMD_PROGRAM, fcs_pkg::CMD_BYP_ENTER, fcs_pkg::CMD_AUTOSEL,
      fcs_pkg::CMD_CHIP_ERS, fcs_pkg::CMD_SECT_ERS: begin
        case (i)
          3'd0, 3'd3: seq_word = {fcs_pkg::A_555, fcs_pkg::D_UNLOCK1};
          3'd1, 3'd4: seq_word = {fcs_pkg::A_2AA, fcs_pkg::D_UNLOCK2};
          3'd2: seq_word = {fcs_pkg::A_555, third};
          default: seq_word = {fcs_pkg::A_555, fcs_pkg::D_CHIP};
        endcase
        if (c == fcs_pkg::CMD_PROGRAM && i == 3'd3)
          seq_word = {a, d};
        if (c == fcs_pkg::CMD_SECT_ERS && i == 3'd5)
          seq_word = {a, fcs_pkg::D_SECTOR};
      end
      fcs_pkg::CMD_BYP_PROG:
        seq_word = (i == 3'd0) ? {fcs_pkg::A_ANY, fcs_pkg::D_PROGRAM}
                               : {a, d};
      fcs_pkg::CMD_BYP_EXIT:
        seq_word = (i == 3'd0) ? {fcs_pkg::A_ANY, fcs_pkg::D_BYP_EX1}
                               : {fcs_pkg::A_ANY, fcs_pkg::D_BYP_EX2};
      fcs_pkg::CMD_SECT_ADD: seq_word = {a, fcs_pkg::D_SECTOR};
      fcs_pkg::CMD_SUSPEND:
        seq_word = {fcs_pkg::A_ANY, fcs_pkg::D_SUSPEND};
      fcs_pkg::CMD_RESUME:
        seq_word = {fcs_pkg::A_ANY, fcs_pkg::D_RESUME};
      default: seq_word = {fcs_pkg::A_ANY, fcs_pkg::D_RESET};
    endcase
  endfunction

  // =====================================================
  // sequencer
  fcs_st_t     st;
  logic [3:0]  cur_cmd;
  logic [16:0] uaddr;
  logic [7:0]  udata;
  logic [2:0]  idx;
  logic [7:0]  prev;
  logic        have_prev;
  logic        recheck;
  logic        fail;

  wire [2:0]  seq_n      = seq_len(cur_cmd);
  wire [24:0] word       = seq_word(cur_cmd, idx, uaddr, udata);
  wire        seq_end    = (idx == seq_n);
  wire        wants_poll = (cur_cmd == fcs_pkg::CMD_PROGRAM)  ||
                           (cur_cmd == fcs_pkg::CMD_BYP_PROG) ||
                           (cur_cmd == fcs_pkg::CMD_CHIP_ERS) ||
                           (cur_cmd == fcs_pkg::CMD_POLL);
  wire        wants_read = (cur_cmd == fcs_pkg::CMD_READ) ||
                           (cur_cmd == fcs_pkg::CMD_AUTOSEL);
  wire [7:0]  rd         = cyc.rdata;
  wire        tog_same   = (rd[fcs_pkg::TOGGLE_BIT] ==
                            prev[fcs_pkg::TOGGLE_BIT]);

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      st        <= S_IDLE;
      cur_cmd   <= fcs_pkg::CMD_READ;
      uaddr     <= 17'h00000;
      udata     <= 8'h00;
      idx       <= 3'd0;
      prev      <= 8'h00;
      have_prev <= 1'b0;
      recheck   <= 1'b0;
      fail      <= 1'b0;
      cmd_ready <= 1'b1;
      rsp_valid <= 1'b0;
      rsp_data  <= 8'h00;
      rsp_fail  <= 1'b0;
      cyc.req   <= 1'b0;
      cyc.wr    <= 1'b0;
      cyc.addr  <= 17'h00000;
      cyc.wdata <= 8'h00;
    end else begin
      case (st)
        S_IDLE: begin
          rsp_valid <= 1'b0;
          if (cmd_valid && cmd_ready) begin
            cur_cmd   <= cmd_code;
            uaddr     <= cmd_addr;
            udata     <= cmd_data;
            idx       <= 3'd0;
            have_prev <= 1'b0;
            recheck   <= 1'b0;
            fail      <= 1'b0;
            cmd_ready <= 1'b0;
            st        <= S_SEQ;
          end
        end
        S_SEQ: begin
          if (seq_end) begin
            st <= wants_poll ? S_POLL : (wants_read ? S_FIN : S_DONE);
          end else begin
            cyc.req   <= 1'b1;
            cyc.wr    <= 1'b1;
            cyc.addr  <= word[24:8];
            cyc.wdata <= word[7:0];
            st        <= S_SEQ_W;
          end
        end
        S_SEQ_W: begin
          cyc.req <= 1'b0;
          if (cyc.done) begin
            idx <= idx + 3'd1;
            st  <= S_SEQ;
          end
        end
        S_POLL: begin
          // status read at the target so the polling bit is valid too
          cyc.req  <= 1'b1;
          cyc.wr   <= 1'b0;
          cyc.addr <= uaddr;
          st       <= S_POLL_W;
        end
        S_POLL_W: begin
          cyc.req <= 1'b0;
          if (cyc.done) begin
            prev <= rd;
            if (!have_prev) begin
              have_prev <= 1'b1;
              st        <= S_POLL;
            end else if (tog_same) begin
              st <= S_FIN;
            end else if (recheck) begin
              fail <= 1'b1;
              st   <= S_ABORT;
            end else begin
              // limit bit may rise as toggling stops, so look once more
              recheck <= rd[fcs_pkg::LIMIT_BIT];
              st      <= S_POLL;
            end
          end
        end
        S_FIN: begin
          // a fresh read, as bit 7 may settle apart from the rest
          cyc.req  <= 1'b1;
          cyc.wr   <= 1'b0;
          cyc.addr <= uaddr;
          st       <= S_FIN_W;
        end
        S_FIN_W: begin
          cyc.req <= 1'b0;
          if (cyc.done) begin
            rsp_data <= rd;
            st       <= S_DONE;
          end
        end
        S_ABORT: begin
          cyc.req   <= 1'b1;
          cyc.wr    <= 1'b1;
          cyc.addr  <= fcs_pkg::A_ANY;
          cyc.wdata <= fcs_pkg::D_RESET;
          st        <= S_ABORT_W;
        end
        S_ABORT_W: begin
          cyc.req <= 1'b0;
          if (cyc.done) begin
            rsp_data <= prev;
            st       <= S_DONE;
          end
        end
        S_DONE: begin
          rsp_valid <= 1'b1;
          rsp_fail  <= fail;
          cmd_ready <= 1'b1;
          st        <= S_IDLE;
        end
        default: st <= S_IDLE;
      endcase
    end
  end
endmodule

// ===== fcs_ctrl_assertions.sv
`timescale 1ns/10ps
// ==========================================
// port protocol checks for the controller
module fcs_ctrl_assertions (
  input wire logic        clk_sys,
  input wire logic        resetn,
  input wire logic        cmd_valid,
  input wire logic [3:0]  cmd_code,
  input wire logic [16:0] cmd_addr,
  input wire logic [7:0]  cmd_data,
  input wire logic        cmd_ready,
  input wire logic        rsp_valid,
  input wire logic [7:0]  rsp_data,
  input wire logic        rsp_fail,
  input wire logic [16:0] fl_addr,
  input wire logic [7:0]  fl_dq_out,
  input wire logic        fl_dq_oe,
  input wire logic [7:0]  fl_dq_in,
  input wire logic        fl_ce_n,
  input wire logic        fl_we_n,
  input wire logic        fl_oe_n
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  a_take_busy: assert property (cmd_valid && cmd_ready |=> !cmd_ready)
    else $error("ready high after a take");
  a_rsp_pulse: assert property (rsp_valid |-> cmd_ready ##1 !rsp_valid)
    else $error("response not one cycle with ready");
  a_idle: assert property (cmd_ready |-> fl_ce_n && fl_we_n && fl_oe_n)
    else $error("flash strobes active while idle");
  a_we_setup: assert property ($fell(fl_we_n) |-> !$past(fl_ce_n))
    else $error("write strobe fell without chip select");
  a_we_width: assert property ($fell(fl_we_n) |=> fl_we_n)
    else $error("write pulse width wrong");
  a_wr_hold: assert property (
    !fl_we_n |-> fl_dq_oe && $stable({fl_addr, fl_dq_out}))
    else $error("write address or data moved");
  a_we_end: assert property ($rose(fl_we_n) |-> !fl_ce_n ##1 fl_ce_n)
    else $error("chip select not released after write strobe");
  a_rd_len: assert property (
    $fell(fl_oe_n) |-> !fl_oe_n[*5] ##1 fl_oe_n)
    else $error("read strobe length wrong");
  a_rd_bus: assert property (!fl_oe_n |-> !fl_dq_oe && fl_we_n)
    else $error("bus driven during a read");
  a_fail_f0: assert property (
    rsp_valid && rsp_fail |-> fl_dq_out == 8'hF0)
    else $error("failure reported without reset write");
  c_fail: cover property (rsp_valid && rsp_fail);
  c_ok: cover property (rsp_valid && !rsp_fail);
  c_write: cover property ($rose(fl_we_n));
endmodule

bind fcs_ctrl fcs_ctrl_assertions chk_u (.*);

// ===== fcs_cyc_if.sv
`timescale 1ns/10ps
interface fcs_cyc_if;
  logic        req;
  logic        wr;
  logic [16:0] addr;
  logic [7:0]  wdata;
  logic        done;
  logic [7:0]  rdata;
  modport ctrl (output req, output wr, output addr, output wdata,
                input done, input rdata);
  modport eng  (input req, input wr, input addr, input wdata,
                output done, output rdata);
endinterface

// ===== fcs_flash_model.sv
`timescale 1ns/10ps
// ==========================================
// behavioural flash on the far side
module fcs_flash_model #(
  parameter logic [7:0] MAKER_ID = 8'h3C,
  parameter logic [7:0] DEV_ID   = 8'hC3,
  parameter int         BUSY_RD  = 4,
  parameter logic [4:0] PROT_SEC = 5'h1E
) (
  input  wire logic [16:0] fl_addr,
  input  wire logic [7:0]  fl_dq_out,
  input  wire logic        fl_ce_n,
  input  wire logic        fl_we_n,
  input  wire logic        fl_oe_n,
  input  wire logic        fail_en,
  output logic      [7:0]  fl_dq_in
);
  logic [7:0]  mem [0:131071];
  logic [16:0] wa;
  logic [7:0]  pv;
  logic [7:0]  v;
  logic [7:0]  last = 8'h00;
  logic [4:0]  sec;
  int          ph   = 0;
  int          busy = 0;
  bit          byp, asel, prg, sers, sus, tg, tg2;
  wire         rdw  = !fl_ce_n && !fl_oe_n;
  initial foreach (mem[i]) mem[i] = 8'hFF;
  // ==========================================
  // read path; a released bus never repeats the last byte
  always @* begin
    v = mem[fl_addr];
    // suspended erase: sectors outside the selection read as array data
    if (busy > 0 && !(sus && fl_addr[16:12] != sec))
      v = {prg ? ~pv[7] : sus, tg, fail_en, 1'b0,
           !prg && busy < BUSY_RD, tg2, 2'b00};
    if (asel)
      v = fl_addr[1] ? {7'h00, fl_addr[16:12] == PROT_SEC}
                     : (fl_addr[0] ? DEV_ID : MAKER_ID);
    fl_dq_in = rdw ? v : ~last;
  end
  always @(negedge rdw) begin
    last = v;
    if (busy > 0 && !prg && (!sers || fl_addr[16:12] == sec))
      tg2 = !tg2;
    if (busy > 0 && !sus) begin
      tg = !tg;
      if (!fail_en)
        busy--;
      // a protected sector keeps its data; status runs a while, but never ends while fail_en holds busy
      if (busy == 0 && !prg)
        foreach (mem[i])
          if (i[16:12] != PROT_SEC && (!sers || i[16:12] == sec))
            mem[i] = 8'hFF;
    end
  end
  // ==========================================
  // write decode
  always @(negedge fl_we_n or negedge fl_ce_n)
    if (!fl_we_n && !fl_ce_n) wa = fl_addr;
  always @(posedge fl_we_n or posedge fl_ce_n)
    if (!fl_we_n || !fl_ce_n) wr(wa, fl_dq_out);
  task automatic wr(input logic [16:0] a, input logic [7:0] d);
    bit u1;
    bit u2;
    u1 = a[10:0] == 11'h555;
    u2 = a[10:0] == 11'h2AA;
    // program data of F0 is data, not a reset
    if (d == 8'hF0 && ph != 3) begin
      ph = 0;
      asel = 0;
      if (fail_en) busy = 0;
    end else if (busy > 0 && !sus) begin
      if (d == 8'hB0 && sers) sus = 1;
    end else if (sus && ph == 0 && d == 8'h30) sus = 0;
    else case (ph)
      0: begin
        if (u1 && d == 8'hAA) ph = 1;
        if (byp && d == 8'hA0) ph = 3;
        if (byp && d == 8'h90) ph = 7;
      end
      1: ph = u2 && d == 8'h55 ? 2 : 0;
      2: begin
        ph = !u1 ? 0 : d == 8'hA0 ? 3 : d == 8'h80 ? 4 : 0;
        if (u1 && d == 8'h20) byp = 1;
        if (u1 && d == 8'h90) asel = 1;
      end
      3: begin
        if (a[16:12] != PROT_SEC)
          mem[a] = mem[a] & d;
        pv = d;
        prg = 1;
        busy = BUSY_RD;
        ph = 0;
      end
      4: ph = u1 && d == 8'hAA ? 5 : 0;
      5: ph = u2 && d == 8'h55 ? 6 : 0;
      6: begin
        ph = 0;
        prg = 0;
        sec = a[16:12];
        sers = d == 8'h30;
        if (sers || (u1 && d == 8'h10)) busy = BUSY_RD;
      end
      default: begin
        ph = 0;
        if (d == 8'h00) byp = 0;
      end
    endcase
  endtask
endmodule

// ===== fcs_pkg.sv
// Contract
// - writing F0 anywhere returns the flash to array reads; used to abort
// - program: AA/555, 55/2AA, A0/555, then data to target address
// - bypass entry AA/555, 55/2AA, 20/555; then program is A0, data
// - bypass exit is 90 then 00 at any address
// - erase: AA,55,80,AA,55 then 10/555 chip or 30/sector address
// - autoselect AA,55,90/555 then read maker at 00, device at 01
// - valid data only on the read after polling shows true data
package fcs_pkg;
  localparam int CLK_PERIOD_NS = 40;
  localparam int T_WP_NS       = 35;
  localparam int T_ACC_NS      = 70;
  localparam int WP_CYC_I  = (T_WP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ACC_CYC_I = (T_ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] WP_CYC   = 4'(WP_CYC_I < 1 ? 1 : WP_CYC_I);
  // two extra cycles cover the data input synchroniser
  localparam logic [3:0] READ_CYC = 4'((ACC_CYC_I < 1 ? 1 : ACC_CYC_I) + 2);

  localparam logic [16:0] A_555 = 17'h00555;
  localparam logic [16:0] A_2AA = 17'h002AA;
  localparam logic [16:0] A_ANY = 17'h00000;
  localparam logic [7:0] D_UNLOCK1  = 8'hAA;
  localparam logic [7:0] D_UNLOCK2  = 8'h55;
  localparam logic [7:0] D_RESET    = 8'hF0;
  localparam logic [7:0] D_PROGRAM  = 8'hA0;
  localparam logic [7:0] D_BYPASS   = 8'h20;
  localparam logic [7:0] D_BYP_EX1  = 8'h90;
  localparam logic [7:0] D_BYP_EX2  = 8'h00;
  localparam logic [7:0] D_AUTOSEL  = 8'h90;
  localparam logic [7:0] D_ERASE    = 8'h80;
  localparam logic [7:0] D_CHIP     = 8'h10;
  localparam logic [7:0] D_SECTOR   = 8'h30;
  localparam logic [7:0] D_SUSPEND  = 8'hB0;
  localparam logic [7:0] D_RESUME   = 8'h30;

  localparam int POLL_BIT   = 7;
  localparam int TOGGLE_BIT = 6;
  localparam int LIMIT_BIT  = 5;

  localparam logic [3:0] CMD_READ      = 4'h0;
  localparam logic [3:0] CMD_RESET     = 4'h1;
  localparam logic [3:0] CMD_PROGRAM   = 4'h2;
  localparam logic [3:0] CMD_BYP_ENTER = 4'h3;
  localparam logic [3:0] CMD_BYP_PROG  = 4'h4;
  localparam logic [3:0] CMD_BYP_EXIT  = 4'h5;
  localparam logic [3:0] CMD_CHIP_ERS  = 4'h6;
  localparam logic [3:0] CMD_SECT_ERS  = 4'h7;
  localparam logic [3:0] CMD_SECT_ADD  = 4'h8;
  localparam logic [3:0] CMD_SUSPEND   = 4'h9;
  localparam logic [3:0] CMD_RESUME    = 4'hA;
  localparam logic [3:0] CMD_AUTOSEL   = 4'hB;
  localparam logic [3:0] CMD_POLL      = 4'hC;
endpackage

// ===== tb_fcs_ctrl.sv
`timescale 1ns/10ps
// ==========================================
// controller against a behavioural flash
module tb_fcs_ctrl;
  localparam logic [7:0] MK_ID = 8'h3C; // arbitrary identity value
  localparam logic [7:0] DV_ID = 8'hC3; // arbitrary identity value
  logic        clk_sys   = 1'h0;
  logic        resetn    = 1'h0;
  logic        cmd_valid = 1'h0;
  logic        fail_en   = 1'h0;
  logic [3:0]  cmd_code  = 4'h0;
  logic [16:0] cmd_addr  = 17'h00000;
  logic [7:0]  cmd_data  = 8'h00;
  logic [7:0]  last      = 8'h00;
  logic [7:0]  bm [logic [16:0]];
  int          num_errors = 0;
  int          n_compared = 0;
  wire         cmd_ready, rsp_valid, rsp_fail, fl_dq_oe;
  wire         fl_ce_n, fl_we_n, fl_oe_n;
  wire  [7:0]  rsp_data, fl_dq_out, fl_dq_in;
  wire  [16:0] fl_addr;
  always #20 clk_sys = ~clk_sys;
  fcs_ctrl dut_u (.*);
  fcs_flash_model #(.MAKER_ID(MK_ID), .DEV_ID(DV_ID)) far_u (.*);
  // ==========================================
  // shared tasks
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    n_compared++;
    if (s !== e) begin
      num_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  function automatic logic [7:0] rd(input logic [16:0] a);
    return bm.exists(a) ? bm[a] : 8'hFF;
  endfunction
  task automatic cmd(input logic [3:0] c, input logic [16:0] a,
                     input logic [7:0] d);
    int n;
    @(posedge clk_sys);
    cmd_valid <= 1'h1;
    cmd_code  <= c;
    cmd_addr  <= a;
    cmd_data  <= d;
    @(posedge clk_sys);
    while (cmd_ready !== 1'h1) @(posedge clk_sys);
    cmd_valid <= 1'h0;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (rsp_valid !== 1'h1 && n < 20000);
    if (n >= 20000) begin
      num_errors++;
      finish_test();
    end
  endtask
  task automatic op(input logic [3:0] c, input logic [16:0] a,
                    input logic [7:0] d, input logic [7:0] e);
    cmd(c, a, d);
    chk(rsp_data, e);
    chk({7'h00, rsp_fail}, 8'h00);
    last = e;
  endtask
  task automatic finish_test;
    $display("compared %0d errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial begin
    #(40 * 60000);
    num_errors++;
    finish_test();
  end
  // ==========================================
  // scenarios
  initial begin
    logic [16:0] a;
    logic [16:0] a0;
    logic [7:0]  d;
    logic [7:0]  e;
    logic [7:0]  s0;
    logic [16:0] sel [4] = '{17'h00000, 17'h00001, 17'h1F002, 17'h1E002};
    logic [7:0]  ids [4] = '{MK_ID, DV_ID, 8'h00, 8'h01};
    void'($urandom(33));
    repeat (8) @(posedge clk_sys);
    chk({cmd_ready, rsp_valid, rsp_fail, fl_ce_n, fl_we_n, fl_oe_n,
         fl_dq_oe, 1'h0}, 8'h9C);
    chk(rsp_data, 8'h00);
    resetn <= 1'h1;
    op(fcs_pkg::CMD_CHIP_ERS, 17'h00000, 8'h00, 8'hFF);
    a0 = 17'h00000;
    repeat (6) begin
      a = 17'($urandom) & 17'h0FFFF;
      d = 8'($urandom);
      e = rd(a) & d;
      bm[a] = e;
      op(fcs_pkg::CMD_PROGRAM, a, d, e);
      op(fcs_pkg::CMD_READ, a, 8'h00, e);
      a0 = a;
    end
    op(fcs_pkg::CMD_BYP_ENTER, 17'h00000, 8'h00, last);
    bm[17'h00123] = rd(17'h00123) & 8'h5A;
    op(fcs_pkg::CMD_BYP_PROG, 17'h00123, 8'h5A, bm[17'h00123]);
    op(fcs_pkg::CMD_BYP_EXIT, 17'h00000, 8'h00, last);
    op(fcs_pkg::CMD_READ, 17'h00123, 8'h00, bm[17'h00123]);
    for (int i = 0; i < 4; i++) begin
      op(fcs_pkg::CMD_AUTOSEL, sel[i], 8'h00, ids[i]);
      op(fcs_pkg::CMD_RESET, 17'h00000, 8'h00, last);
    end
    op(fcs_pkg::CMD_READ, a0, 8'h00, rd(a0));
    // protected sector: program runs, data stays erased
    op(fcs_pkg::CMD_PROGRAM, 17'h1E010, 8'h00, rd(17'h1E010));
    op(fcs_pkg::CMD_READ, 17'h1E010, 8'h00, rd(17'h1E010));
    bm[17'h12345] = 8'h00;
    op(fcs_pkg::CMD_PROGRAM, 17'h12345, 8'h00, 8'h00);
    op(fcs_pkg::CMD_SECT_ERS, 17'h12000, 8'h00, 8'h00);
    op(fcs_pkg::CMD_SECT_ADD, 17'h12000, 8'h00, 8'h00);
    cmd(fcs_pkg::CMD_READ, 17'h12345, 8'h00);
    s0 = rsp_data;
    chk(s0 & 8'hAB, 8'h00);
    // both toggle bits flip on the next read, erase timer has run out
    e = {1'b0, ~s0[6], 3'b001, ~s0[2], 2'b00};
    op(fcs_pkg::CMD_READ, 17'h12345, 8'h00, e);
    op(fcs_pkg::CMD_SUSPEND, 17'h00000, 8'h00, last);
    op(fcs_pkg::CMD_READ, a0, 8'h00, rd(a0));
    cmd(fcs_pkg::CMD_READ, 17'h12345, 8'h00);
    chk({7'h00, rsp_data[7]}, 8'h01);
    cmd(fcs_pkg::CMD_RESUME, 17'h00000, 8'h00);
    foreach (bm[k]) if (k[16:12] == 5'h12) bm[k] = 8'hFF;
    op(fcs_pkg::CMD_POLL, 17'h12345, 8'h00, 8'hFF);
    op(fcs_pkg::CMD_READ, 17'h12345, 8'h00, 8'hFF);
    fail_en <= 1'h1;
    bm[17'h00700] = rd(17'h00700) & 8'h11;
    cmd(fcs_pkg::CMD_PROGRAM, 17'h00700, 8'h11);
    chk({6'h00, rsp_fail, rsp_data[5]}, 8'h03);
    fail_en <= 1'h0;
    op(fcs_pkg::CMD_READ, 17'h00700, 8'h00, rd(17'h00700));
    op(4'hF, 17'h00000, 8'h00, last);
    finish_test();
  end
endmodule
